/* File: lochc_pkg.sv */
// Constants shared by the LED output channel control block.
// Assumes a single 40 MHz clock and an AXI4-Lite master on the register side.
package lochc_pkg;

	// ==========================================================
	// Sizes
	localparam int NOUT        = 12;
	localparam int NPWM        = 6;
	localparam int CODEW       = 8;
	localparam int DUTYW       = 10;
	localparam int SELW        = 3;
	localparam int ADDRW       = 8;
	localparam int PREW        = 16;
	localparam int STEP_BASE   = 7;
	localparam int STEP_MAX    = 3;
	localparam int CODES_PER_W = 4;
	localparam int SELS_PER_W  = 8;
	localparam int SEL_NIB     = 4;
	localparam int N_CODE_W    = 3;
	localparam int N_SEL_W     = 2;

	// ==========================================================
	// Register byte addresses
	localparam logic [ADDRW-1:0] A_CTRL  = 8'h00;
	localparam logic [ADDRW-1:0] A_CMD   = 8'h04;
	localparam logic [ADDRW-1:0] A_MASK  = 8'h08;
	localparam logic [ADDRW-1:0] A_HSE   = 8'h0c;
	localparam logic [ADDRW-1:0] A_GSE   = 8'h10;
	localparam logic [ADDRW-1:0] A_OPE   = 8'h14;
	localparam logic [ADDRW-1:0] A_STATE = 8'h18;
	localparam logic [ADDRW-1:0] A_STAT  = 8'h1c;
	localparam logic [ADDRW-1:0] A_RSH   = 8'h20;
	localparam logic [ADDRW-1:0] A_RSL   = 8'h24;
	localparam logic [ADDRW-1:0] A_ROP   = 8'h28;
	localparam logic [ADDRW-1:0] A_DUTY  = 8'h40;
	localparam logic [ADDRW-1:0] A_CODE  = 8'h60;
	localparam logic [ADDRW-1:0] A_SEL   = 8'h70;

	// ==========================================================
	// Fields and command bits
	localparam int F_STEP = 0;
	localparam int F_FREQ = 4;
	localparam int C_UNL_CUR = 0;
	localparam int C_LCK_CUR = 1;
	localparam int C_UNL_MSK = 2;
	localparam int C_LCK_MSK = 3;
	localparam int C_CLR_FLG = 4;
	localparam int C_CAPTURE = 5;
	localparam int S_CUR_UNL = 0;
	localparam int S_MSK_UNL = 1;
	localparam int S_SHORT   = 2;
	localparam int S_OPEN    = 3;

	// ==========================================================
	// Codes and reset values
	localparam logic [SELW-1:0]  SEL_FULL_LO = 3'h0;
	localparam logic [SELW-1:0]  SEL_FULL_HI = 3'h7;
	localparam logic [1:0]       RESP_OKAY   = 2'h0;
	localparam logic [1:0]       RESP_SLVERR = 2'h2;
	localparam logic [NOUT-1:0]  RST_RESULT  = 12'hfff;
	localparam logic [CODEW-1:0] RST_CODE    = 8'h00;

endpackage

/* File: lochc_sync.sv */
// Two-stage synchroniser for a bus of independent level inputs.
// Assumes each bit is a slow level from a pin, not a multi-bit word.
module lochc_sync
	import lochc_pkg::*;
#(
	parameter int W = NOUT
) (
	input  wire logic         clock_i,
	input  wire logic         arst_n_i,
	input  wire logic [W-1:0] async_i,
	output logic      [W-1:0] sync_o
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} lochc_sync_st_t;

	lochc_sync_st_t q;
	lochc_sync_st_t d;

	always_comb begin
		d    = q;
		d.s1 = async_i;
		d.s2 = q.s1;
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign sync_o = q.s2;

endmodule

/* File: lochc_pwm.sv */
// Six PWM channels sharing one frame counter.
// Assumes step and frequency settings are stable over a frame.
module lochc_pwm
	import lochc_pkg::*;
#(
	parameter int PRESC = 16
) (
	input  wire logic                  clock_i,
	input  wire logic                  arst_n_i,
	input  wire logic [1:0]            step_i,
	input  wire logic [3:0]            freq_i,
	input  wire logic [NPWM*DUTYW-1:0] duty_i,
	output logic      [NPWM-1:0]       pwm_o
);

	typedef struct packed {
		logic [PREW-1:0]  pre;
		logic [DUTYW-1:0] cnt;
		logic [NPWM-1:0]  pwm;
	} lochc_pwm_st_t;

	lochc_pwm_st_t    q;
	lochc_pwm_st_t    d;
	logic [DUTYW-1:0] top;
	logic [DUTYW-1:0] dv;

	always_comb begin
		d   = q;
		dv  = '0;
		top = DUTYW'((1 << (STEP_BASE + int'(step_i))) - 1);
		if (q.pre == '0) begin
			d.pre = PREW'((int'(freq_i) + 1) * PRESC - 1);
			d.cnt = (q.cnt >= top) ? '0 : q.cnt + 1'b1;
		end else begin
			d.pre = q.pre - 1'b1;
		end
		// Low duty bits are dropped at coarse resolutions, so code+1 steps are lit.
		for (int m = 0; m < NPWM; m++) begin
			dv       = duty_i[m*DUTYW +: DUTYW] >> (STEP_MAX - int'(step_i));
			d.pwm[m] = (q.cnt <= dv);
		end
	end

	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign pwm_o = q.pwm;

endmodule

/* File: lochc_top.sv */
// Channel control for twelve LED outputs behind an AXI4-Lite slave.
// Assumes arst_n_i already combines the reset pin and the supply detector.
//
// Added by the designer: register access over AXI4-Lite and the register offsets.
module lochc_top
	import lochc_pkg::*;
#(
	parameter int PRESC = 16
) (
	input  wire logic                  clock_i,
	input  wire logic                  arst_n_i,
	input  wire logic [ADDRW-1:0]      awaddr_i,
	input  wire logic                  awvalid_i,
	output logic                       awready_o,
	input  wire logic [31:0]           wdata_i,
	input  wire logic [3:0]            wstrb_i,
	input  wire logic                  wvalid_i,
	output logic                       wready_o,
	output logic      [1:0]            bresp_o,
	output logic                       bvalid_o,
	input  wire logic                  bready_i,
	input  wire logic [ADDRW-1:0]      araddr_i,
	input  wire logic                  arvalid_i,
	output logic                       arready_o,
	output logic      [31:0]           rdata_o,
	output logic      [1:0]            rresp_o,
	output logic                       rvalid_o,
	input  wire logic                  rready_i,
	input  wire logic [NOUT-1:0]       high_short_det_i,
	input  wire logic [NOUT-1:0]       gnd_short_det_i,
	input  wire logic [NOUT-1:0]       open_det_i,
	output logic      [NOUT-1:0]       led_output_o,
	output logic      [NOUT*CODEW-1:0] channel_current_code_o,
	output logic                       err_o,
	output logic                       err_oe_o
);

	// ==========================================================
	// State
	typedef struct packed {
		logic                        awready;
		logic                        awv;
		logic [ADDRW-1:0]            aw;
		logic                        wready;
		logic                        wv;
		logic [31:0]                 wd;
		logic [3:0]                  ws;
		logic                        bv;
		logic [1:0]                  bresp;
		logic                        arready;
		logic                        rv;
		logic [31:0]                 rd;
		logic [1:0]                  rresp;
		logic                        cur_unl;
		logic                        msk_unl;
		logic [1:0]                  step;
		logic [3:0]                  freq;
		logic [NOUT-1:0]             mask;
		logic [NOUT-1:0]             hse;
		logic [NOUT-1:0]             gse;
		logic [NOUT-1:0]             ope;
		logic [NPWM-1:0][DUTYW-1:0]  duty;
		logic [NOUT-1:0][CODEW-1:0]  code;
		logic [NOUT-1:0][SELW-1:0]   sel;
		logic [NOUT-1:0]             state;
		logic [NOUT-1:0]             rsh;
		logic [NOUT-1:0]             rsl;
		logic [NOUT-1:0]             rop;
		logic [NOUT-1:0]             led;
		logic                        err;
	} lochc_st_t;

	lochc_st_t                 q;
	lochc_st_t                 d;
	logic [NPWM-1:0]           pwm;
	logic [NOUT-1:0]           hs_s;
	logic [NOUT-1:0]           gs_s;
	logic [NOUT-1:0]           op_s;
	logic [NPWM*DUTYW-1:0]     duty_flat;
	logic [31:0]               wm;
	logic [31:0]               cmd;
	logic [SELW-1:0]           s;
	logic [ADDRW-1:0]          a;

	// ==========================================================
	// Decoding
	function automatic logic addr_ok(input logic [ADDRW-1:0] ad);
		logic ok;
		ok = (ad <= A_ROP) && (ad[1:0] == 2'h0);
		ok = ok || (ad >= A_DUTY && ad < A_DUTY + ADDRW'(4 * NPWM) && ad[1:0] == 2'h0);
		ok = ok || (ad >= A_CODE && ad < A_CODE + ADDRW'(4 * N_CODE_W) && ad[1:0] == 2'h0);
		ok = ok || (ad >= A_SEL && ad < A_SEL + ADDRW'(4 * N_SEL_W) && ad[1:0] == 2'h0);
		return ok;
	endfunction

	function automatic int word_idx(input logic [ADDRW-1:0] ad, input logic [ADDRW-1:0] base);
		logic [ADDRW-1:0] off;
		off = ad - base;
		return int'(off[ADDRW-1:2]);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[b*8 +: 8] = nw[b*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [31:0] rdmux(input logic [ADDRW-1:0] ad, input lochc_st_t st);
		logic [31:0] r;
		int          w;
		r = '0;
		w = 0;
		if (ad == A_CTRL) begin
			r[F_STEP +: 2] = st.step;
			r[F_FREQ +: 4] = st.freq;
		end else if (ad == A_MASK) begin
			r[NOUT-1:0] = st.mask;
		end else if (ad == A_HSE) begin
			r[NOUT-1:0] = st.hse;
		end else if (ad == A_GSE) begin
			r[NOUT-1:0] = st.gse;
		end else if (ad == A_OPE) begin
			r[NOUT-1:0] = st.ope;
		end else if (ad == A_STATE) begin
			r[NOUT-1:0] = st.state;
		end else if (ad == A_STAT) begin
			r[S_CUR_UNL] = st.cur_unl;
			r[S_MSK_UNL] = st.msk_unl;
			r[S_SHORT]   = |(st.rsh | st.rsl);
			r[S_OPEN]    = |st.rop;
		end else if (ad == A_RSH) begin
			r[NOUT-1:0] = st.rsh;
		end else if (ad == A_RSL) begin
			r[NOUT-1:0] = st.rsl;
		end else if (ad == A_ROP) begin
			r[NOUT-1:0] = st.rop;
		end else if (ad >= A_DUTY && ad < A_CODE) begin
			w = word_idx(ad, A_DUTY);
			r[DUTYW-1:0] = st.duty[w];
		end else if (ad >= A_CODE && ad < A_SEL) begin
			w = word_idx(ad, A_CODE);
			for (int k = 0; k < CODES_PER_W; k++) begin
				r[k*CODEW +: CODEW] = st.code[w*CODES_PER_W + k];
			end
		end else if (ad >= A_SEL) begin
			w = word_idx(ad, A_SEL);
			for (int k = 0; k < SELS_PER_W; k++) begin
				if (w*SELS_PER_W + k < NOUT) begin
					r[k*SEL_NIB +: SELW] = st.sel[w*SELS_PER_W + k];
				end
			end
		end
		return r;
	endfunction

	// ==========================================================
	// Submodules
	lochc_sync #(
		.W(3 * NOUT)
	) u_sync (
		.clock_i (clock_i),
		.arst_n_i(arst_n_i),
		.async_i ({high_short_det_i, gnd_short_det_i, open_det_i}),
		.sync_o  ({hs_s, gs_s, op_s})
	);

	assign duty_flat = q.duty;

	lochc_pwm #(
		.PRESC(PRESC)
	) u_pwm (
		.clock_i (clock_i),
		.arst_n_i(arst_n_i),
		.step_i  (q.step),
		.freq_i  (q.freq),
		.duty_i  (duty_flat),
		.pwm_o   (pwm)
	);

	// ==========================================================
	// Next state
	always_comb begin
		d   = q;
		wm  = merge(q.wd, q.wd, 4'h0);
		cmd = '0;
		s   = '0;
		a   = q.aw;
		if (q.bv && bready_i) begin
			d.bv = 1'b0;
		end
		if (q.rv && rready_i) begin
			d.rv = 1'b0;
		end
		if (q.awready && awvalid_i) begin
			d.awv = 1'b1;
			d.aw  = awaddr_i;
		end
		if (q.wready && wvalid_i) begin
			d.wv = 1'b1;
			d.wd = wdata_i;
			d.ws = wstrb_i;
		end
		// Address and data are held until both are in and the last response is gone.
		if (q.awv && q.wv && !q.bv) begin
			d.awv   = 1'b0;
			d.wv    = 1'b0;
			d.bv    = 1'b1;
			d.bresp = addr_ok(a) ? RESP_OKAY : RESP_SLVERR;
			if (a == A_CMD) begin
				// Only byte lane 0 carries command bits.
				cmd = q.wd & 32'({8{q.ws[0]}});
			end else if (a == A_CTRL) begin
				wm     = merge({24'h0, q.freq, 2'h0, q.step}, q.wd, q.ws);
				d.step = wm[F_STEP +: 2];
				d.freq = wm[F_FREQ +: 4];
			end else if (a == A_MASK || a == A_HSE || a == A_GSE || a == A_OPE) begin
				if (q.msk_unl) begin
					wm = merge(rdmux(a, q), q.wd, q.ws);
					unique case (a)
						A_MASK: d.mask = wm[NOUT-1:0];
						A_HSE:  d.hse  = wm[NOUT-1:0];
						A_GSE:  d.gse  = wm[NOUT-1:0];
						default: d.ope = wm[NOUT-1:0];
					endcase
				end
			end else if (a >= A_DUTY && a < A_DUTY + ADDRW'(4 * NPWM) && addr_ok(a)) begin
				wm = merge(rdmux(a, q), q.wd, q.ws);
				d.duty[word_idx(a, A_DUTY)] = wm[DUTYW-1:0];
			end else if (a >= A_CODE && a < A_SEL && addr_ok(a)) begin
				// codes held, writes dropped while locked
				if (q.cur_unl) begin
					wm = merge(rdmux(a, q), q.wd, q.ws);
					for (int k = 0; k < CODES_PER_W; k++) begin
						d.code[word_idx(a, A_CODE)*CODES_PER_W + k] = wm[k*CODEW +: CODEW];
					end
				end
			end else if (a >= A_SEL && addr_ok(a)) begin
				wm = merge(rdmux(a, q), q.wd, q.ws);
				for (int k = 0; k < SELS_PER_W; k++) begin
					if (word_idx(a, A_SEL)*SELS_PER_W + k < NOUT) begin
						d.sel[word_idx(a, A_SEL)*SELS_PER_W + k] = wm[k*SEL_NIB +: SELW];
					end
				end
			end
		end
		d.awready = !d.awv;
		d.wready  = !d.wv;

		if (q.arready && arvalid_i) begin
			d.rv    = 1'b1;
			d.rd    = addr_ok(araddr_i) ? rdmux(araddr_i, q) : '0;
			d.rresp = addr_ok(araddr_i) ? RESP_OKAY : RESP_SLVERR;
		end
		d.arready = !d.rv;

		if (cmd[C_UNL_CUR]) begin
			d.cur_unl = 1'b1;
		end
		if (cmd[C_LCK_CUR]) begin
			d.cur_unl = 1'b0;
		end
		if (cmd[C_UNL_MSK]) begin
			d.msk_unl = 1'b1;
		end
		if (cmd[C_LCK_MSK]) begin
			d.msk_unl = 1'b0;
		end

		for (int n = 0; n < NOUT; n++) begin
			s = q.sel[n];
			if (s == SEL_FULL_LO || s == SEL_FULL_HI) begin
				d.led[n] = q.mask[n];
			end else begin
				d.led[n] = q.mask[n] & pwm[int'(s) - 1];
			end
		end

		if (cmd[C_CLR_FLG]) begin
			d.state = '0;
			d.rsh   = '0;
			d.rsl   = '0;
			d.rop   = '0;
		end
		if (cmd[C_CAPTURE]) begin
			d.state = q.led;
		end
		d.rsh = d.rsh | (hs_s & q.hse);
		d.rsl = d.rsl | (gs_s & q.gse);
		d.rop = d.rop | (op_s & q.ope);
		d.err = |(d.rsh | d.rsl | d.rop);
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q         <= '0;
			q.awready <= 1'b1;
			q.wready  <= 1'b1;
			q.arready <= 1'b1;
			q.code    <= {NOUT{RST_CODE}};
			q.rsh     <= RST_RESULT;
			q.rsl     <= RST_RESULT;
			q.rop     <= RST_RESULT;
			q.err     <= 1'b1;
		end else begin
			q <= d;
		end
	end

	// ==========================================================
	// Outputs
	assign awready_o              = q.awready;
	assign wready_o               = q.wready;
	assign bvalid_o               = q.bv;
	assign bresp_o                = q.bresp;
	assign arready_o              = q.arready;
	assign rvalid_o               = q.rv;
	assign rdata_o                = q.rd;
	assign rresp_o                = q.rresp;
	assign led_output_o           = q.led;
	assign channel_current_code_o = q.code;
	assign err_oe_o               = q.err;
	// The error pin is open drain: it only ever pulls low.
	assign err_o                  = 1'b0;

endmodule

/* File: lochc_load.sv */
// Far-side model: the LED loads as seen by the output detectors.
// Assumes the bench chooses which loads are open; shorts are never shown.
module lochc_load
	import lochc_pkg::*;
(
	input  wire logic            clock_i,
	input  wire logic [NOUT-1:0] open_load_i,
	output logic      [NOUT-1:0] high_short_det_o,
	output logic      [NOUT-1:0] gnd_short_det_o,
	output logic      [NOUT-1:0] open_det_o
);
	// ==========================================================
	// Detector levels
	// open load flagged
	always_ff @(posedge clock_i) begin
		open_det_o <= open_load_i;
	end
	assign high_short_det_o = '0;
	assign gnd_short_det_o  = '0;
endmodule

/* File: lochc_chk.sv */
// Concurrent checks on the ports of the channel control top.
// Assumes one clock domain and the asynchronous active-low reset.
module lochc_chk
	import lochc_pkg::*;
#(
	parameter int PRESC = 16
) (
	input  wire logic                  clock_i,
	input  wire logic                  arst_n_i,
	input  wire logic                  awvalid_i,
	input  wire logic                  awready_o,
	input  wire logic                  wvalid_i,
	input  wire logic                  wready_o,
	input  wire logic [1:0]            bresp_o,
	input  wire logic                  bvalid_o,
	input  wire logic                  bready_i,
	input  wire logic                  arvalid_i,
	input  wire logic                  arready_o,
	input  wire logic [31:0]           rdata_o,
	input  wire logic                  rvalid_o,
	input  wire logic                  rready_i,
	input  wire logic [NOUT-1:0]       led_output_o,
	input  wire logic [NOUT*CODEW-1:0] channel_current_code_o,
	input  wire logic                  err_o,
	input  wire logic                  err_oe_o
);
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);

	// ==========================================================
	// Assertions
	chk_state_reset: assert property ($rose(arst_n_i) |-> led_output_o == '0
		&& channel_current_code_o == '0) else $error("outputs not cleared by reset");
	chk_err_reset: assert property ($rose(arst_n_i) |-> err_oe_o)
		else $error("error pin not pulled after reset");
	chk_err_level: assert property (err_oe_o |-> err_o == 1'b0)
		else $error("error pin driven high");
	chk_code_write: assert property ($changed(channel_current_code_o) |-> $rose(bvalid_o))
		else $error("current code changed without a write");
	chk_write_lat: assert property (awvalid_i && awready_o && wvalid_i && wready_o |-> ##2 bvalid_o)
		else $error("write response late");
	chk_bresp_hold: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
		else $error("write response dropped");
	chk_read_lat: assert property (arvalid_i && arready_o |=> rvalid_o ##0 !arready_o)
		else $error("read answer late");
	chk_rdata_hold: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
		else $error("read data dropped");

	// ==========================================================
	// Coverage
	cover property ($rose(bvalid_o) && bresp_o == RESP_SLVERR);
	cover property ($changed(channel_current_code_o));
	cover property ($fell(err_oe_o));
endmodule

bind lochc_top lochc_chk #(.PRESC(PRESC)) lochc_chk_i (.*);

/* File: tb_top.sv */
// Self-checking bench for the channel control top with an AXI4-Lite master.
// Assumes the load model and the checker bound onto the top.
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import lochc_pkg::*;

	localparam int SEL_TAB [NOUT] = '{1, 2, 3, 4, 5, 6, 0, 7, 1, 1, 1, 1};
	logic                  clock_i = 1'b0;
	logic                  arst_n_i = 1'b0;
	logic [ADDRW-1:0]      awaddr_i = '0;
	logic [ADDRW-1:0]      araddr_i = '0;
	logic                  awvalid_i = 1'b0;
	logic                  wvalid_i = 1'b0;
	logic                  bready_i = 1'b0;
	logic                  arvalid_i = 1'b0;
	logic                  rready_i = 1'b0;
	logic [31:0]           wdata_i = '0;
	logic [3:0]            wstrb_i = 4'hf;
	logic                  awready_o, wready_o, bvalid_o, arready_o, rvalid_o, err_o, err_oe_o;
	logic [1:0]            bresp_o, rresp_o, resp;
	logic [31:0]           rdata_o, rd;
	logic [NOUT-1:0]       high_short_det_i, gnd_short_det_i, open_det_i, led_output_o;
	logic [NOUT-1:0]       open_load = '0;
	logic [NOUT*CODEW-1:0] channel_current_code_o;
	logic [9:0]            duty [NPWM];
	logic [31:0]           code [N_CODE_W];
	int                    cnt [NOUT];
	int                    seed = 32'hcf93;
	int                    n_fail = 0;
	int                    compares = 0;

	always #12.5 clock_i = ~clock_i;

	// A short step prescale keeps a whole PWM frame inside a few hundred cycles.
	lochc_top #(.PRESC(1)) lochc_top_i (.*);
	lochc_load lochc_load_i (
		.clock_i          (clock_i),
		.open_load_i      (open_load),
		.high_short_det_o (high_short_det_i),
		.gnd_short_det_o  (gnd_short_det_i),
		.open_det_o       (open_det_i)
	);

	// ==========================================================
	// Bus tasks and checks
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic ap, wp;
		ap = 1'b1;
		wp = 1'b1;
		@(posedge clock_i);
		awaddr_i <= a;
		wdata_i <= d;
		awvalid_i <= 1'b1;
		wvalid_i <= 1'b1;
		bready_i <= 1'b1;
		do begin
			@(posedge clock_i);
			if (ap && awready_o) begin
				ap = 1'b0;
				awvalid_i <= 1'b0;
			end
			if (wp && wready_o) begin
				wp = 1'b0;
				wvalid_i <= 1'b0;
			end
		end while (ap || wp);
		do @(posedge clock_i); while (!bvalid_o);
		resp = bresp_o;
		bready_i <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a);
		@(posedge clock_i);
		araddr_i <= a;
		arvalid_i <= 1'b1;
		rready_i <= 1'b1;
		do @(posedge clock_i); while (!arready_o);
		arvalid_i <= 1'b0;
		do @(posedge clock_i); while (!rvalid_o);
		rd = rdata_o;
		resp = rresp_o;
		rready_i <= 1'b0;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("ERROR %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask

	function automatic int exp_cnt(input int k, input int s);
		logic [2:0] sel;
		sel = 3'(SEL_TAB[k]);
		if (k >= 8) return 0;
		if (sel == SEL_FULL_LO || sel == SEL_FULL_HI) return 256;
		return (s == 0) ? 2 * ((duty[sel-1] >> 3) + 1) : (duty[sel-1] >> 2) + 1;
	endfunction

	task automatic end_sim;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// ==========================================================
	// Scenarios
	initial begin
		for (int k = 0; k < NPWM; k++) duty[k] = 10'($random(seed));
		repeat (10) @(posedge clock_i);
		arst_n_i <= 1'b1;
		rd_reg(A_STATE);
		chk(rd & 32'hfff, 32'h0, "state after reset");
		chk(32'(err_oe_o), 32'h1, "error pin after reset");
		wr(A_CODE, $random(seed));
		chk(channel_current_code_o[31:0], 32'h0, "locked code write");
		wr(A_CMD, 32'h1 << C_UNL_CUR);
		for (int i = 0; i < N_CODE_W; i++) begin
			code[i] = $random(seed);
			wr(A_CODE + 8'(4 * i), code[i]);
			chk(channel_current_code_o[32*i +: 32], code[i], "current code");
		end
		wr(A_CMD, 32'h1 << C_LCK_CUR);
		wr(A_CODE, ~code[0]);
		chk(channel_current_code_o[31:0], code[0], "relocked code write");
		wr(A_MASK, 32'hfff);
		rd_reg(A_MASK);
		chk(rd, 32'h0, "locked mask write");
		wr(A_CMD, 32'h1 << C_UNL_MSK);
		wstrb_i <= 4'h1;
		wr(A_MASK, 32'hfff);
		wstrb_i <= 4'hf;
		rd_reg(A_MASK);
		chk(rd, 32'h0ff, "mask write, lane 0 only");
		wr(A_SEL, 32'h7065_4321);
		wr(A_SEL + 8'h04, 32'h0000_1111);
		for (int k = 0; k < NPWM; k++) wr(A_DUTY + 8'(4 * k), 32'(duty[k]));
		// The third pass halves the step rate, so one frame still spans the 256-cycle window.
		for (int s = 0; s < 3; s++) begin
			wr(A_CTRL, (s == 2) ? 32'h1 << F_FREQ : 32'(s));
			repeat (300) @(posedge clock_i);
			cnt = '{default: 0};
			repeat (256) begin
				@(posedge clock_i);
				for (int k = 0; k < NOUT; k++) if (led_output_o[k] === 1'b1) cnt[k]++;
			end
			for (int k = 0; k < NOUT; k++) begin
				chk(32'(cnt[k]), 32'(exp_cnt(k, s % 2)), "lit cycles");
			end
		end
		for (int k = 0; k < NPWM; k++) wr(A_DUTY + 8'(4 * k), 32'h3ff);
		wr(A_CMD, 32'h1 << C_CAPTURE);
		wr(A_MASK, 32'h00f);
		rd_reg(A_STATE);
		chk(rd, 32'h0ff, "captured state");
		wr(A_CMD, 32'h1 << C_CLR_FLG);
		rd_reg(A_STATE);
		chk(rd, 32'h0, "state after flag clear");
		chk(32'(err_oe_o), 32'h0, "error pin after clear");
		open_load <= 12'h801;
		wr(A_OPE, 32'h001);
		repeat (8) @(posedge clock_i);
		rd_reg(A_ROP);
		chk(rd, 32'h001, "open result");
		chk(32'(err_oe_o), 32'h1, "error pin on open");
		rd_reg(A_STAT);
		chk(rd, (32'h1 << S_OPEN) | (32'h1 << S_MSK_UNL), "status summary");
		wr(8'hfc, 32'h1);
		chk(32'(resp), 32'(RESP_SLVERR), "unmapped write");
		rd_reg(8'hfc);
		chk(rd, 32'h0, "unmapped read");
		chk(32'(resp), 32'(RESP_SLVERR), "unmapped read response");
		wr(A_CMD, 32'h1 << C_CAPTURE);
		rd_reg(A_STATE);
		chk(rd, 32'h00f, "recaptured state");
		arst_n_i <= 1'b0;
		repeat (2) @(posedge clock_i);
		arst_n_i <= 1'b1;
		rd_reg(A_STATE);
		chk(rd, 32'h0, "state after mid-run reset");
		end_sim;
	end

	// The whole sequence takes a few thousand cycles; this bound catches a hang.
	initial begin
		repeat (20000) @(posedge clock_i);
		n_fail++;
		end_sim;
	end
endmodule
